// [hdl/atf_flags.sv]
// Status flags of an advanced control timer, with APB registers and interrupt.
// Counter, repetition counter and commutation source live outside on clk.
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "atf_params.svh"

module atf_flags #(
	parameter int CNT_W = 16,
	parameter int CHANNELS = 4
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`ATF_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic brakePin,
	input wire logic triggerPin,
	input wire logic [CHANNELS-1:0] capturePin,
	input wire logic [CNT_W-1:0] counterValue,
	input wire logic countDown,
	input wire logic repOverflow,
	input wire logic counterReinit,
	input wire logic comRequest,
	output logic updateEvent,
	output logic comEvent,
	output atf_pkg::atf_chmode_type activeMode,
	output logic irq
);
	import atf_pkg::*;

	atf_evt_if #(.CHANNELS(CHANNELS)) evt ();

	atf_ctrl_type ctrl_q;
	atf_flags_type mask_q;
	atf_flags_type flags_q;
	atf_flags_type flags_d;
	atf_chmode_type preMode_q;
	logic [CNT_W-1:0] ccr_q [CHANNELS];
	logic ugPend_q;
	logic comPend_q;
	logic [31:0] rdata_d;

	atf_pin_front #(.CHANNELS(CHANNELS)) atf_pin_front_inst (
		.clk(clk),
		.reset(reset),
		.brakePin(brakePin),
		.triggerPin(triggerPin),
		.capturePin(capturePin),
		.brakeActiveHigh(ctrl_q[`ATF_CTL_BRKHIGH]),
		.gatedMode(ctrl_q[`ATF_CTL_GATED]),
		.triggerFalling(ctrl_q[`ATF_CTL_TRGFALL]),
		.evt(evt)
	);

	// Bus decode; a transfer completes in its first access cycle
	wire setupPhase = psel & ~penable;
	wire done = psel & penable & pready;
	wire wrDone = done & pwrite;
	wire rdDone = done & ~pwrite;
	wire hitCtrl = paddr == `ATF_OFF_CTRL;
	wire hitMask = paddr == `ATF_OFF_MASK;
	wire hitStat = paddr == `ATF_OFF_STAT;
	wire hitEvgen = paddr == `ATF_OFF_EVGEN;
	wire hitPre = paddr == `ATF_OFF_PRE;
	wire hitAct = paddr == `ATF_OFF_ACT;
	wire hitCcr = paddr >= `ATF_OFF_CCR && paddr <= `ATF_OFF_CCR_LAST
		&& paddr[1:0] == 2'h0;
	wire [1:0] ccrSel = 2'(({24'h0, paddr} - {24'h0, `ATF_OFF_CCR}) >> 2);
	wire mapped = hitCtrl | hitMask | hitStat | hitEvgen | hitPre | hitAct | hitCcr;

	// Software event requests
	wire ugWrite = wrDone & hitEvgen & pwdata[`ATF_BIT_UPD];
	wire comWrite = wrDone & hitEvgen & pwdata[`ATF_BIT_COM];

	// Update sources
	wire update_disable = ctrl_q[`ATF_CTL_UPDATE_DISABLE];
	wire update_request_source = ctrl_q[`ATF_CTL_URS];
	wire updOverflow = repOverflow & ~update_disable;
	wire updSoftware = (ugPend_q | counterReinit) & ~update_disable & ~update_request_source;
	wire updNow = updOverflow | updSoftware;

	// Commutation: hardware request or software generate
	wire comNow = comRequest | comPend_q;

	// Per-channel set and read-clear terms
	logic [CHANNELS-1:0] ccSet;
	logic [CHANNELS-1:0] ccRdClr;

	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
			wire isInput = activeMode[ch];
			wire match = counterValue == ccr_q[ch];
			// Centre-aligned counting takes the up-counting match only
			wire centreOk = ~ctrl_q[`ATF_CTL_CENTRE] | ~countDown;
			wire capNow = isInput & evt.captureEdge[ch];
			assign ccSet[ch] = isInput ? capNow
				: (match & centreOk);
			assign ccRdClr[ch] = isInput & rdDone & hitCcr
				& (ccrSel == 2'(ch));

			always_ff @(posedge clk) begin
				if (reset) begin
					ccr_q[ch] <= '0;
				end else if (capNow) begin
					ccr_q[ch] <= counterValue;
				end else if (wrDone & hitCcr & ~isInput & ccrSel == 2'(ch)) begin
					ccr_q[ch] <= pwdata[CNT_W-1:0];
				end
			end
		end
	endgenerate

	// Flag sets gathered in status layout
	wire [`ATF_STAT_W-1:0] setVec = {
		evt.brakeLevel,
		evt.triggerEvent,
		comNow,
		ccSet,
		updNow
	};

	// Writing zero clears, writing one keeps
	wire [`ATF_STAT_W-1:0] swClr = (wrDone & hitStat)
		? ~pwdata[`ATF_STAT_W-1:0] : '0;
	wire [`ATF_STAT_W-1:0] rdClr = {3'h0, ccRdClr, 1'b0};

	always_comb begin
		// Set applied last so a same-cycle event survives
		flags_d = (flags_q & ~(swClr | rdClr)) | setVec;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			flags_q <= `ATF_RST_STAT;
		end else begin
			flags_q <= flags_d;
		end
	end

	// Control, mask and preload mode registers
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_q <= `ATF_RST_CTRL;
			mask_q <= `ATF_RST_MASK;
			preMode_q <= `ATF_RST_CHM;
		end else begin
			if (wrDone & hitCtrl) begin
				ctrl_q <= pwdata[`ATF_CTL_W-1:0];
			end
			if (wrDone & hitMask) begin
				mask_q <= pwdata[`ATF_STAT_W-1:0];
			end
			if (wrDone & hitPre) begin
				preMode_q <= pwdata[`ATF_CHM_W-1:0];
			end
		end
	end

	// Software generate bits act one cycle after the write
	always_ff @(posedge clk) begin
		if (reset) begin
			ugPend_q <= 1'b0;
			comPend_q <= 1'b0;
		end else begin
			ugPend_q <= ugWrite;
			comPend_q <= comWrite;
		end
	end

	// Preload copied into the live controls at commutation
	always_ff @(posedge clk) begin
		if (reset) begin
			activeMode <= `ATF_RST_CHM;
		end else if (comNow) begin
			activeMode <= preMode_q;
		end
	end

	// Registered event strobes for the timer core
	always_ff @(posedge clk) begin
		if (reset) begin
			updateEvent <= 1'b0;
			comEvent <= 1'b0;
		end else begin
			updateEvent <= updNow;
			comEvent <= comNow;
		end
	end

	// Level interrupt from unmasked flags, follows flags with one cycle lag
	always_ff @(posedge clk) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(flags_q & mask_q);
		end
	end

	// Read mux; generate register reads as zero
	always_comb begin
		rdata_d = 32'h0;
		if (hitCtrl) begin
			rdata_d[`ATF_CTL_W-1:0] = ctrl_q;
		end else if (hitMask) begin
			rdata_d[`ATF_STAT_W-1:0] = mask_q;
		end else if (hitStat) begin
			rdata_d[`ATF_STAT_W-1:0] = flags_q;
		end else if (hitPre) begin
			rdata_d[`ATF_CHM_W-1:0] = preMode_q;
		end else if (hitAct) begin
			rdata_d[`ATF_CHM_W-1:0] = activeMode;
		end else if (hitCcr) begin
			rdata_d[CNT_W-1:0] = ccr_q[ccrSel];
		end
	end

	// Data sampled at setup; status may move before the access edge
	always_ff @(posedge clk) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= setupPhase;
			pslverr <= setupPhase & ~mapped;
			if (setupPhase & ~pwrite) begin
				prdata <= rdata_d;
			end
		end
	end
endmodule : atf_flags

`default_nettype wire

// [hdl/atf_params.svh]
// Constants for the timer status flag block: offsets, bit positions, resets.
// Included by the package and the design modules; defines only.
`ifndef ATF_PARAMS_SVH
`define ATF_PARAMS_SVH

`define ATF_ADDR_W 8
`define ATF_OFF_CTRL 8'h00
`define ATF_OFF_MASK 8'h04
`define ATF_OFF_STAT 8'h08
`define ATF_OFF_EVGEN 8'h0C
`define ATF_OFF_PRE 8'h10
`define ATF_OFF_ACT 8'h14
`define ATF_OFF_CCR 8'h18
`define ATF_OFF_CCR_LAST 8'h24

`define ATF_STAT_W 8
`define ATF_BIT_UPD 0
`define ATF_BIT_CC 1
`define ATF_BIT_COM 5
`define ATF_BIT_TRG 6
`define ATF_BIT_BRK 7

`define ATF_CTL_UPDATE_DISABLE 0
`define ATF_CTL_URS 1
`define ATF_CTL_GATED 2
`define ATF_CTL_TRGFALL 3
`define ATF_CTL_BRKHIGH 4
`define ATF_CTL_CENTRE 5
`define ATF_CTL_W 6

`define ATF_CHM_W 24
`define ATF_CHM_OE 4
`define ATF_CHM_NE 8
`define ATF_CHM_OCM 12
`define ATF_OCM_W 3

`define ATF_RST_CTRL 6'h00
`define ATF_RST_STAT 8'h00
`define ATF_RST_MASK 8'h00
`define ATF_RST_CHM 24'h000000
// Brake synchroniser resets to the idle level of the low-active default
`define ATF_RST_BRKSYNC 2'h3

`endif

// [hdl/atf_pkg.sv]
// Types shared by the timer status flag block.
// Needs atf_params.svh on the include path.
`include "atf_params.svh"

package atf_pkg;
	typedef logic [`ATF_STAT_W-1:0] atf_flags_type;
	typedef logic [`ATF_CTL_W-1:0] atf_ctrl_type;
	typedef logic [`ATF_CHM_W-1:0] atf_chmode_type;
endpackage : atf_pkg

// [hdl/atf_evt_if.sv]
// Event carrier between the pin front end and the flag core.
// Both ends on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface atf_evt_if #(parameter int CHANNELS = 4);
	logic brakeLevel;
	logic triggerEvent;
	logic [CHANNELS-1:0] captureEdge;
	modport gen (output brakeLevel, output triggerEvent, output captureEdge);
	modport core (input brakeLevel, input triggerEvent, input captureEdge);
endinterface : atf_evt_if

`default_nettype wire

// [hdl/atf_pin_front.sv]
// Pin front end: synchronises brake, trigger and capture pins, finds edges.
// Pins are asynchronous to clk; control bits come from the core's registers.
`timescale 1ns/1ps
`default_nettype none
`include "atf_params.svh"

module atf_pin_front #(
	parameter int CHANNELS = 4
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic brakePin,
	input wire logic triggerPin,
	input wire logic [CHANNELS-1:0] capturePin,
	input wire logic brakeActiveHigh,
	input wire logic gatedMode,
	input wire logic triggerFalling,
	atf_evt_if.gen evt
);
	logic [1:0] brkSync_q;
	logic [2:0] trgSync_q;
	logic [2:0] capSync_q [CHANNELS];
	wire trgRise = trgSync_q[1] & ~trgSync_q[2];
	wire trgFall = ~trgSync_q[1] & trgSync_q[2];

	always_ff @(posedge clk) begin
		if (reset) begin
			// A zero here would fake a brake right after reset
			brkSync_q <= `ATF_RST_BRKSYNC;
			trgSync_q <= 3'h0;
		end else begin
			brkSync_q <= {brkSync_q[0], brakePin};
			trgSync_q <= {trgSync_q[1:0], triggerPin};
		end
	end

	// Active level chosen by software
	assign evt.brakeLevel = brkSync_q[1] == brakeActiveHigh;
	// Gated mode counts both edges
	assign evt.triggerEvent = gatedMode ? (trgRise | trgFall)
		: (triggerFalling ? trgFall : trgRise);

	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_cap
			always_ff @(posedge clk) begin
				if (reset) begin
					capSync_q[ch] <= 3'h0;
				end else begin
					capSync_q[ch] <= {capSync_q[ch][1:0], capturePin[ch]};
				end
			end
			assign evt.captureEdge[ch] = capSync_q[ch][1] & ~capSync_q[ch][2];
		end
	endgenerate
endmodule : atf_pin_front

`default_nettype wire

// [test/atf_flags_assertions.sv]
// Checker for the timer flag block.
// Sees only the top ports; one clock.
`timescale 1ns/1ps
`default_nettype none

module atf_flags_assertions (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic repOverflow,
	input wire logic counterReinit,
	input wire logic comRequest,
	input wire logic updateEvent,
	input wire logic comEvent,
	input wire atf_pkg::atf_chmode_type activeMode,
	input wire logic irq
);
	import atf_pkg::*;
	logic wrAcc;
	logic [3:0] updQ;
	logic [3:0] comQ;
	assign wrAcc = psel & penable & pwrite;
	// Causes of the last four edges
	always_ff @(posedge clk) begin
		updQ <= {updQ[2:0], repOverflow | counterReinit | wrAcc};
		comQ <= {comQ[2:0], comRequest | wrAcc};
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	setup_ready_a: assert property (psel && !penable |=> pready)
		else $error("no ready");
	ready_single_a: assert property (pready |=> !pready)
		else $error("long ready");
	error_ready_a: assert property (pslverr |-> pready)
		else $error("stray error");
	rdata_hold_a: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
		else $error("read data moved");
	update_cause_a: assert property ($rose(updateEvent) |-> |updQ)
		else $error("stray update");
	com_cause_a: assert property ($rose(comEvent) |-> |comQ)
		else $error("stray commutation");
	mode_on_com_a: assert property ($changed(activeMode) |-> ##[0:2] comEvent)
		else $error("mode moved");
	reset_quiet_a: assert property ($fell(reset) |-> !pready && !irq && !updateEvent)
		else $error("busy after reset");
	cover property (updateEvent);
	cover property (comEvent);
	cover property (irq);
endmodule : atf_flags_assertions

bind atf_flags atf_flags_assertions atf_flags_assertions_inst (.clk, .reset, .psel, .penable,
	.pwrite, .prdata, .pready, .pslverr, .repOverflow, .counterReinit, .comRequest,
	.updateEvent, .comEvent, .activeMode, .irq);

`default_nettype wire

// [test/atf_pins_model.sv]
// Brake and trigger sources outside the timer.
// Pins move just after a clock edge.
`timescale 1ns/1ps
`default_nettype none

module atf_pins_model (
	input wire logic clk,
	output logic brakePin,
	output logic triggerPin
);
	// Brake idles high: inactive for the low-active default
	initial begin
		brakePin = 1'b1;
		triggerPin = 1'b0;
	end
	task automatic brake(input logic lvl);
		@(posedge clk);
		brakePin <= lvl;
	endtask : brake
	task automatic toggle();
		@(posedge clk);
		triggerPin <= !triggerPin;
	endtask : toggle
endmodule : atf_pins_model

`default_nettype wire

// [test/atf_flags_bench.sv]
// Self-checking bench for the timer flag block.
// Needs the pin model and the checker.
`timescale 1ns/1ps
`default_nettype none
`include "atf_params.svh"

module atf_flags_bench;
	import atf_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] capturePin = 4'h0;
	logic [15:0] counterValue = 16'h1234;
	logic countDown = 1'b0;
	logic repOverflow = 1'b0;
	logic counterReinit = 1'b0;
	logic comRequest = 1'b0;
	logic brakePin, triggerPin, pready, pslverr, irq, rerr;
	logic updateEvent, comEvent;
	logic [31:0] prdata, rdat;
	int failCount = 0;
	int checkCount = 0;
	always #2.5 clk = ~clk;
	atf_pins_model atf_pins_model_inst (.clk, .brakePin, .triggerPin);
	atf_flags atf_flags_inst (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .brakePin, .triggerPin, .capturePin, .counterValue, .countDown,
		.repOverflow, .counterReinit, .comRequest, .updateEvent, .comEvent, .activeMode(),
		.irq);
	task automatic stopTest();
		if (failCount == 0 && checkCount > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stopTest
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			failCount++;
			$display("MISMATCH %0t %h %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 8);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			failCount++;
			stopTest();
		end
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask : rd
	// Pins pass a synchroniser first
	task automatic srd(input logic [31:0] e);
		repeat (5) @(posedge clk);
		rd(`ATF_OFF_STAT, e);
	endtask : srd
	task automatic clr();
		wr(`ATF_OFF_STAT, 32'h0);
	endtask : clr
	task automatic hit();
		counterValue <= 16'h0055;
		@(posedge clk);
		counterValue <= 16'h1234;
	endtask : hit
	task automatic tUpdate();
		rd(`ATF_OFF_CTRL, 32'h0);
		apb(1'b0, 8'hFC, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		wr(`ATF_OFF_EVGEN, 32'h1);
		srd(32'h1);
		chk({31'h0, irq}, 32'h0);
		wr(`ATF_OFF_MASK, 32'h1);
		srd(32'h1);
		chk({31'h0, irq}, 32'h1);
		wr(`ATF_OFF_STAT, 32'hFF);
		rd(`ATF_OFF_STAT, 32'h1);
		clr();
		wr(`ATF_OFF_CTRL, 32'h1);
		repOverflow <= 1'b1;
		@(posedge clk);
		repOverflow <= 1'b0;
		srd(32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(`ATF_OFF_CTRL, 32'h2);
		counterReinit <= 1'b1;
		@(posedge clk);
		counterReinit <= 1'b0;
		srd(32'h0);
		repOverflow <= 1'b1;
		@(posedge clk);
		repOverflow <= 1'b0;
		@(posedge clk);
		chk({31'h0, updateEvent}, 32'h1);
		srd(32'h1);
		wr(`ATF_OFF_CTRL, 32'h0);
		clr();
	endtask : tUpdate
	task automatic tBrake();
		atf_pins_model_inst.brake(1'b0);
		srd(32'h80);
		clr();
		rd(`ATF_OFF_STAT, 32'h80);
		atf_pins_model_inst.brake(1'b1);
		srd(32'h80);
		clr();
		rd(`ATF_OFF_STAT, 32'h0);
	endtask : tBrake
	task automatic tTrigger();
		atf_pins_model_inst.toggle();
		srd(32'h40);
		clr();
		atf_pins_model_inst.toggle();
		srd(32'h0);
		wr(`ATF_OFF_CTRL, 32'h4);
		atf_pins_model_inst.toggle();
		srd(32'h40);
		clr();
		atf_pins_model_inst.toggle();
		srd(32'h40);
		wr(`ATF_OFF_CTRL, 32'h8);
		clr();
		atf_pins_model_inst.toggle();
		srd(32'h0);
		atf_pins_model_inst.toggle();
		srd(32'h40);
		wr(`ATF_OFF_CTRL, 32'h0);
		clr();
	endtask : tTrigger
	task automatic tCom();
		wr(`ATF_OFF_PRE, 32'hABC0);
		rd(`ATF_OFF_ACT, 32'h0);
		comRequest <= 1'b1;
		@(posedge clk);
		comRequest <= 1'b0;
		@(posedge clk);
		chk({31'h0, comEvent}, 32'h1);
		rd(`ATF_OFF_STAT, 32'h20);
		rd(`ATF_OFF_ACT, 32'hABC0);
		clr();
	endtask : tCom
	task automatic tChannel();
		wr(`ATF_OFF_CCR, 32'h55);
		hit();
		srd(32'h2);
		clr();
		wr(`ATF_OFF_CTRL, 32'h20);
		countDown <= 1'b1;
		hit();
		srd(32'h0);
		countDown <= 1'b0;
		hit();
		srd(32'h2);
		wr(`ATF_OFF_CTRL, 32'h0);
		wr(`ATF_OFF_PRE, 32'h2);
		wr(`ATF_OFF_EVGEN, 32'h20);
		clr();
		capturePin <= 4'h2;
		srd(32'h4);
		rd(`ATF_OFF_CCR + 8'h04, 32'h1234);
		rd(`ATF_OFF_STAT, 32'h0);
	endtask : tChannel
	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		tUpdate();
		tBrake();
		tTrigger();
		tCom();
		tChannel();
		stopTest();
	end
endmodule : atf_flags_bench

`default_nettype wire
